// [flash_cmd_read_path.sv]
`timescale 1ns/1ps
`default_nettype none
module flash_cmd_read_path (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic cs_pin_b,
    input wire logic sck_pin,
    input wire logic bidir_in_line_in,
    output logic bidir_in_line_out,
    output logic bidir_in_line_oe_b,
    output logic so_out,
    output logic so_oe_b,
    output logic [18:0] mem_addr,
    input wire logic [7:0] mem_data,
    output logic [7:0] cmd_code,
    output logic [18:0] cmd_addr,
    output logic cmd_strobe,
    output logic [7:0] wdata,
    output logic wdata_strobe
);
    spi_link_if lnk ();

    spi_pin_sync u_sync (
        .mclk(mclk),
        .rst_b(rst_b),
        .cs_pin_b(cs_pin_b),
        .sck_pin(sck_pin),
        .si_pin(bidir_in_line_in),
        .lnk(lnk)
    );

    flash_cmd_pkg::seq_state_e state_reg, state_next;
    flash_cmd_pkg::decode_s dec_reg, dec_next;
    logic [2:0] bit_reg, bit_next;
    logic [1:0] byte_reg, byte_next;
    logic [7:0] in_reg, in_next;
    logic [7:0] opc_reg, opc_next;
    logic [18:0] addr_reg, addr_next;
    logic [7:0] out_sh_reg, out_sh_next;
    logic [7:0] wdata_reg, wdata_next;
    logic seq_reg, seq_next;
    logic so_reg, so_next;
    logic lo_bit_reg, lo_bit_next;
    logic oe_reg, oe_next;
    logic cmd_strobe_reg, cmd_strobe_next;
    logic wdata_strobe_reg, wdata_strobe_next;
    logic [7:0] in_byte;
    logic byte_end;
    logic go;
    logic is_dual;
    flash_cmd_pkg::decode_s dec_now;

    assign in_byte = {in_reg[6:0], lnk.si_bit};
    assign byte_end = lnk.sck_rise && (bit_reg == flash_cmd_pkg::LAST_BIT);
    assign dec_now = flash_cmd_pkg::decode(in_byte, seq_reg);
    assign is_dual = (dec_reg.kind == flash_cmd_pkg::K_DUAL);

    // command sequencer next state
    always_comb begin
        state_next = state_reg;
        dec_next = dec_reg;
        bit_next = bit_reg;
        byte_next = byte_reg;
        in_next = in_reg;
        opc_next = opc_reg;
        addr_next = addr_reg;
        out_sh_next = out_sh_reg;
        wdata_next = wdata_reg;
        seq_next = seq_reg;
        so_next = so_reg;
        lo_bit_next = lo_bit_reg;
        oe_next = oe_reg;
        cmd_strobe_next = 1'b0;
        wdata_strobe_next = 1'b0;
        go = 1'b0;
        if (!lnk.cs_act) begin
            state_next = flash_cmd_pkg::ST_IDLE;
            oe_next = 1'b0;
            bit_next = 3'h0;
        end else begin
            // header shifting at rising clock, except while idle or streaming out
            if (lnk.sck_rise && state_reg != flash_cmd_pkg::ST_READ
                    && state_reg != flash_cmd_pkg::ST_IDLE) begin
                in_next = in_byte;
                bit_next = 3'(bit_reg + 3'h1);
            end
            unique case (state_reg)
                flash_cmd_pkg::ST_IDLE: begin
                    state_next = flash_cmd_pkg::ST_OPC;
                    bit_next = 3'h0;
                end
                flash_cmd_pkg::ST_OPC: begin
                    if (byte_end) begin
                        opc_next = in_byte;
                        dec_next = dec_now;
                        if (!dec_now.ok) begin
                            state_next = flash_cmd_pkg::ST_IGNORE;
                        end else if (dec_now.naddr != 2'h0) begin
                            state_next = flash_cmd_pkg::ST_ADDR;
                            byte_next = 2'(dec_now.naddr - 2'h1);
                        end else if (dec_now.ndum != 2'h0) begin
                            state_next = flash_cmd_pkg::ST_DUMMY;
                            byte_next = 2'(dec_now.ndum - 2'h1);
                        end else begin
                            go = 1'b1;
                        end
                    end
                end
                flash_cmd_pkg::ST_ADDR: begin
                    if (lnk.sck_rise) begin
                        addr_next = {addr_reg[17:0], lnk.si_bit};
                    end
                    if (byte_end) begin
                        if (byte_reg != 2'h0) begin
                            byte_next = 2'(byte_reg - 2'h1);
                        end else if (dec_reg.ndum != 2'h0) begin
                            state_next = flash_cmd_pkg::ST_DUMMY;
                            byte_next = 2'(dec_reg.ndum - 2'h1);
                        end else begin
                            go = 1'b1;
                        end
                    end
                end
                flash_cmd_pkg::ST_DUMMY: begin
                    if (byte_end) begin
                        if (byte_reg != 2'h0) begin
                            byte_next = 2'(byte_reg - 2'h1);
                        end else begin
                            go = 1'b1;
                        end
                    end
                end
                flash_cmd_pkg::ST_DATA: begin
                    if (byte_end) begin
                        wdata_next = in_byte;
                        wdata_strobe_next = 1'b1;
                    end
                end
                flash_cmd_pkg::ST_READ: begin
                    // output changes at the falling clock
                    if (lnk.sck_fall) begin
                        oe_next = 1'b1;
                        if (bit_reg == 3'h0) begin
                            so_next = mem_data[7];
                            lo_bit_next = mem_data[6];
                            out_sh_next = is_dual ? {mem_data[5:0], 2'h0}
                                : {mem_data[6:0], 1'h0};
                            addr_next = flash_cmd_pkg::addr_inc(addr_reg);
                        end else begin
                            so_next = out_sh_reg[7];
                            lo_bit_next = out_sh_reg[6];
                            out_sh_next = is_dual ? {out_sh_reg[5:0], 2'h0}
                                : {out_sh_reg[6:0], 1'h0};
                        end
                        bit_next = 3'(bit_reg + (is_dual ? flash_cmd_pkg::STEP_DUAL
                            : flash_cmd_pkg::STEP_SINGLE));
                    end
                end
                flash_cmd_pkg::ST_IGNORE: begin
                    state_next = flash_cmd_pkg::ST_IGNORE;
                end
                default: state_next = flash_cmd_pkg::ST_IDLE;
            endcase
            // header complete: announce command and pick the data phase
            if (go) begin
                cmd_strobe_next = 1'b1;
                bit_next = 3'h0;
                if (state_reg == flash_cmd_pkg::ST_OPC && dec_now.kind == flash_cmd_pkg::K_WRIN
                        && (in_byte == flash_cmd_pkg::OP_SEQ_PROG_A
                        || in_byte == flash_cmd_pkg::OP_SEQ_PROG_B)) begin
                    addr_next = flash_cmd_pkg::addr_inc(addr_reg);
                end
                seq_next = (opc_next == flash_cmd_pkg::OP_SEQ_PROG_A)
                    || (opc_next == flash_cmd_pkg::OP_SEQ_PROG_B);
                unique case (dec_next.kind)
                    flash_cmd_pkg::K_READ, flash_cmd_pkg::K_DUAL:
                        state_next = flash_cmd_pkg::ST_READ;
                    flash_cmd_pkg::K_WRIN: state_next = flash_cmd_pkg::ST_DATA;
                    default: state_next = flash_cmd_pkg::ST_IGNORE;
                endcase
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            state_reg <= flash_cmd_pkg::ST_IDLE;
            dec_reg <= '{1'b0, 2'h0, 2'h0, flash_cmd_pkg::K_NONE};
            bit_reg <= 3'h0;
            byte_reg <= 2'h0;
            in_reg <= 8'h00;
            opc_reg <= 8'h00;
            addr_reg <= 19'h00000;
            out_sh_reg <= 8'h00;
            wdata_reg <= 8'h00;
            seq_reg <= 1'b0;
            so_reg <= 1'b0;
            lo_bit_reg <= 1'b0;
            oe_reg <= 1'b0;
            cmd_strobe_reg <= 1'b0;
            wdata_strobe_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            dec_reg <= dec_next;
            bit_reg <= bit_next;
            byte_reg <= byte_next;
            in_reg <= in_next;
            opc_reg <= opc_next;
            addr_reg <= addr_next;
            out_sh_reg <= out_sh_next;
            wdata_reg <= wdata_next;
            seq_reg <= seq_next;
            so_reg <= so_next;
            lo_bit_reg <= lo_bit_next;
            oe_reg <= oe_next;
            cmd_strobe_reg <= cmd_strobe_next;
            wdata_strobe_reg <= wdata_strobe_next;
        end
    end

    // pin and user-side outputs
    assign so_out = so_reg;
    assign so_oe_b = ~oe_reg;
    assign bidir_in_line_out = lo_bit_reg;
    assign bidir_in_line_oe_b = ~(oe_reg & is_dual);
    assign mem_addr = addr_reg;
    assign cmd_code = opc_reg;
    assign cmd_addr = addr_reg;
    assign cmd_strobe = cmd_strobe_reg;
    assign wdata = wdata_reg;
    assign wdata_strobe = wdata_strobe_reg;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    release_float_a: assert property (!lnk.cs_act |=> so_oe_b && bidir_in_line_oe_b)
        else $error("output still driven after chip select release");
    early_end_a: assert property (!lnk.cs_act |=> state_reg == flash_cmd_pkg::ST_IDLE
            && !cmd_strobe)
        else $error("operation continued without chip select");
    ignore_hold_a: assert property (state_reg == flash_cmd_pkg::ST_IGNORE && lnk.cs_act
            |=> (state_reg == flash_cmd_pkg::ST_IGNORE) && !wdata_strobe && so_oe_b)
        else $error("ignored operation left its hold state");
    msb_load_a: assert property (state_reg == flash_cmd_pkg::ST_READ && lnk.sck_fall
            && bit_reg == 3'h0 && lnk.cs_act |=> so_out == $past(mem_data[7])
            && bidir_in_line_out == $past(mem_data[6]))
        else $error("first output bit is not the byte's top bit");
    addr_wrap_a: assert property (state_reg == flash_cmd_pkg::ST_READ && lnk.sck_fall
            && bit_reg == 3'h0 && lnk.cs_act && addr_reg == flash_cmd_pkg::ADDR_TOP
            |=> addr_reg == flash_cmd_pkg::ADDR_ZERO)
        else $error("read address did not wrap to zero");
    dual_only_a: assert property (!bidir_in_line_oe_b |-> dec_reg.kind == flash_cmd_pkg::K_DUAL
            && state_reg == flash_cmd_pkg::ST_READ)
        else $error("bidirectional line driven outside dual read");
    fall_change_a: assert property ($changed(so_out) |-> $past(lnk.sck_fall))
        else $error("serial output changed away from a falling clock");
    read_enter_a: assert property (cmd_strobe && dec_reg.kind == flash_cmd_pkg::K_READ
            |-> state_reg == flash_cmd_pkg::ST_READ ##1 so_oe_b [*1])
        else $error("read command did not enter streaming");
    wdata_src_a: assert property (wdata_strobe |-> $past(state_reg) == flash_cmd_pkg::ST_DATA
            && wdata == $past(in_byte))
        else $error("data byte strobe outside data phase");
endmodule : flash_cmd_read_path
`default_nettype wire

// [flash_cmd_pkg.sv]
package flash_cmd_pkg;

    // opcode set
    localparam logic [7:0] OP_READ_FAST = 8'h0b;
    localparam logic [7:0] OP_READ_SLOW = 8'h03;
    localparam logic [7:0] OP_READ_DUAL = 8'h3b;
    localparam logic [7:0] OP_PAGE_ERASE = 8'h81;
    localparam logic [7:0] OP_BLK_ERASE_4K = 8'h20;
    localparam logic [7:0] OP_BLK_ERASE_32K = 8'h52;
    localparam logic [7:0] OP_BLK_ERASE_64K = 8'hd8;
    localparam logic [7:0] OP_CHIP_ERASE_A = 8'h60;
    localparam logic [7:0] OP_CHIP_ERASE_B = 8'hc7;
    localparam logic [7:0] OP_PROG = 8'h02;
    localparam logic [7:0] OP_PROG_DUAL = 8'ha2;
    localparam logic [7:0] OP_SEQ_PROG_A = 8'had;
    localparam logic [7:0] OP_SEQ_PROG_B = 8'haf;
    localparam logic [7:0] OP_WR_ENABLE = 8'h06;
    localparam logic [7:0] OP_WR_DISABLE = 8'h04;
    localparam logic [7:0] OP_PROTECT = 8'h36;
    localparam logic [7:0] OP_UNPROTECT = 8'h39;
    localparam logic [7:0] OP_PROT_READ = 8'h3c;
    localparam logic [7:0] OP_OTP_PROG = 8'h9b;
    localparam logic [7:0] OP_OTP_READ = 8'h77;
    localparam logic [7:0] OP_STAT_READ = 8'h05;
    localparam logic [7:0] OP_STAT_INT = 8'h25;
    localparam logic [7:0] OP_STAT_WR1 = 8'h01;
    localparam logic [7:0] OP_STAT_WR2 = 8'h31;
    localparam logic [7:0] OP_RESET = 8'hf0;
    localparam logic [7:0] OP_ID_READ = 8'h9f;
    localparam logic [7:0] OP_DEEP_PD = 8'hb9;
    localparam logic [7:0] OP_RESUME_PD = 8'hab;
    localparam logic [7:0] OP_ULTRA_PD = 8'h79;

    // array geometry and counts
    localparam int ADDR_W = 19;
    localparam logic [18:0] ADDR_TOP = 19'h7ffff;
    localparam logic [18:0] ADDR_ZERO = 19'h00000;
    localparam logic [1:0] ADDR_BYTES = 2'h3;
    localparam logic [2:0] LAST_BIT = 3'h7;
    localparam logic [2:0] STEP_SINGLE = 3'h1;
    localparam logic [2:0] STEP_DUAL = 3'h2;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_OPC = 3'b001,
        ST_ADDR = 3'b010,
        ST_DUMMY = 3'b011,
        ST_DATA = 3'b100,
        ST_READ = 3'b101,
        ST_IGNORE = 3'b110
    } seq_state_e;

    typedef enum logic [2:0] {
        K_NONE = 3'b000,
        K_READ = 3'b001,
        K_DUAL = 3'b010,
        K_WRIN = 3'b011,
        K_RDOUT = 3'b100,
        K_CTRL = 3'b101
    } cmd_kind_e;

    typedef struct packed {
        logic ok;
        logic [1:0] naddr;
        logic [1:0] ndum;
        cmd_kind_e kind;
    } decode_s;

    // opcode to byte counts and kind; sequential mode drops the address
    function automatic decode_s decode(input logic [7:0] op, input logic seq);
        decode_s d;
        d = '{ok: 1'b1, naddr: 2'h0, ndum: 2'h0, kind: K_CTRL};
        unique case (op)
            OP_READ_FAST: d = '{1'b1, ADDR_BYTES, 2'h1, K_READ};
            OP_READ_SLOW: d = '{1'b1, ADDR_BYTES, 2'h0, K_READ};
            OP_READ_DUAL: d = '{1'b1, ADDR_BYTES, 2'h1, K_DUAL};
            OP_PAGE_ERASE, OP_BLK_ERASE_4K, OP_BLK_ERASE_32K, OP_BLK_ERASE_64K,
            OP_PROTECT, OP_UNPROTECT: d.naddr = ADDR_BYTES;
            OP_CHIP_ERASE_A, OP_CHIP_ERASE_B, OP_WR_ENABLE, OP_WR_DISABLE,
            OP_DEEP_PD, OP_RESUME_PD, OP_ULTRA_PD: d.kind = K_CTRL;
            OP_PROG, OP_PROG_DUAL, OP_OTP_PROG:
                d = '{1'b1, ADDR_BYTES, 2'h0, K_WRIN};
            OP_SEQ_PROG_A, OP_SEQ_PROG_B:
                d = '{1'b1, seq ? 2'h0 : ADDR_BYTES, 2'h0, K_WRIN};
            OP_PROT_READ: d = '{1'b1, ADDR_BYTES, 2'h0, K_RDOUT};
            OP_OTP_READ: d = '{1'b1, ADDR_BYTES, 2'h2, K_RDOUT};
            OP_STAT_READ, OP_ID_READ: d.kind = K_RDOUT;
            OP_STAT_INT: d.ndum = 2'h1;
            OP_STAT_WR1, OP_STAT_WR2, OP_RESET: d.kind = K_WRIN;
            default: d = '{1'b0, 2'h0, 2'h0, K_NONE};
        endcase
        return d;
    endfunction : decode

    // array address step, wraps top to zero with no gap
    function automatic logic [18:0] addr_inc(input logic [18:0] a);
        return (a == ADDR_TOP) ? ADDR_ZERO : 19'(a + 19'h1);
    endfunction : addr_inc

endpackage : flash_cmd_pkg

// [spi_link_if.sv]
`timescale 1ns/1ps
`default_nettype none
// synchronised serial link events, one mclk domain
interface spi_link_if;
    logic cs_act;
    logic sck_rise;
    logic sck_fall;
    logic si_bit;
    modport src (output cs_act, output sck_rise, output sck_fall, output si_bit);
    modport dst (input cs_act, input sck_rise, input sck_fall, input si_bit);
endinterface : spi_link_if
`default_nettype wire

// [spi_pin_sync.sv]
`timescale 1ns/1ps
`default_nettype none
module spi_pin_sync (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic cs_pin_b,
    input wire logic sck_pin,
    input wire logic si_pin,
    spi_link_if.src lnk
);
    // bit 0 sck, bit 1 si, bit 2 cs_b
    logic [2:0] meta_reg, meta_next;
    logic [2:0] sync_reg, sync_next;
    logic sck_prev_reg, sck_prev_next;

    // two-stage synchroniser plus edge history
    always_comb begin
        meta_next = {cs_pin_b, si_pin, sck_pin};
        sync_next = meta_reg;
        sck_prev_next = sync_reg[0];
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            meta_reg <= 3'h4;
            sync_reg <= 3'h4;
            sck_prev_reg <= 1'b0;
        end else begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
            sck_prev_reg <= sck_prev_next;
        end
    end

    // edges taken from the clean copy only
    assign lnk.cs_act = ~sync_reg[2];
    assign lnk.sck_rise = sync_reg[0] & ~sck_prev_reg;
    assign lnk.sck_fall = ~sync_reg[0] & sck_prev_reg;
    assign lnk.si_bit = sync_reg[1];

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    edge_exclusive_a: assert property (!(lnk.sck_rise && lnk.sck_fall))
        else $error("rise and fall flagged together");
    rise_follows_a: assert property (lnk.sck_rise |=> !lnk.sck_rise)
        else $error("rise flag longer than one cycle");
endmodule : spi_pin_sync
`default_nettype wire

// [spi_host.sv]
`timescale 1ns/1ps
`default_nettype none
// host side of the serial link, mode 0, 8 MHz serial clock
module spi_host (
    input wire logic so_out,
    input wire logic so_oe_b,
    input wire logic bidir_out,
    input wire logic bidir_oe_b,
    output logic cs_b,
    output logic sck,
    output logic si_line,
    output logic [7:0] rd_byte,
    output logic rd_tick
);
    logic host_oe = 1'b1;
    logic si_drv = 1'b0;
    logic so_seen;
    // a released line shows the inverse of its last level
    assign so_seen = so_oe_b ? ~so_out : so_out;
    assign si_line = host_oe ? si_drv : (bidir_oe_b ? ~bidir_out : bidir_out);
    initial begin
        cs_b = 1'b1;
        sck = 1'b0;
        rd_byte = 8'h00;
        rd_tick = 1'b0;
    end
    // open a frame and settle before the first clock
    task start();
        cs_b = 1'b0;
        host_oe = 1'b1;
        #62.5;
    endtask : start
    // shift n bits from the top, launch at fall, device samples at rise
    task bits(input logic [7:0] b, input int n);
        for (int i = 0; i < n; i++) begin
            sck = 1'b0;
            si_drv = b[7 - i];
            #62.5;
            sck = 1'b1;
            #62.5;
        end
    endtask : bits
    // collect one byte, four clocks when both lines carry data
    task rd(input logic dual);
        logic [7:0] v;
        v = 8'h00;
        if (dual) host_oe = 1'b0;
        for (int i = 0; i < (dual ? 4 : 8); i++) begin
            sck = 1'b0;
            #62.5;
            sck = 1'b1;
            v = dual ? {v[5:0], so_seen, si_line} : {v[6:0], so_seen};
            #62.5;
        end
        rd_byte = v;
        rd_tick = ~rd_tick;
    endtask : rd
    // park the clock low, deselect, keep a gap
    task stop();
        sck = 1'b0;
        #62.5;
        cs_b = 1'b1;
        #125;
    endtask : stop
endmodule : spi_host
`default_nettype wire

// [testbench.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic cs_b, sck, si_line, rd_tick, bidir_out, bidir_oe_b, so_out, so_oe_b;
    logic cmd_strobe, wdata_strobe;
    logic [7:0] mem_data, cmd_code, wdata, rd_byte;
    logic [18:0] mem_addr, cmd_addr;
    logic [27:0] exp_cmd[$];
    logic [7:0] exp_byte[$];
    int n_errors = 0;
    int cmp_count = 0;
    integer seed = 44;
    // opcode, address bytes, dummy bytes, data-in bytes
    localparam logic [15:0] tbl [0:26] = '{16'h81c0, 16'h20c0, 16'h52c0, 16'hd8c0,
        16'h6000, 16'hc700, 16'h02c4, 16'ha2c4, 16'hadc4, 16'had04, 16'haf04, 16'h0600,
        16'h0400, 16'h36c0, 16'h39c0, 16'h3cc0, 16'h9bc4, 16'h77e0, 16'h0500, 16'h2510,
        16'h0104, 16'h3104, 16'hf004, 16'h9f00, 16'hb900, 16'hab00, 16'h7900};
    always #2 mclk = ~mclk;
    function automatic logic [7:0] mem(input logic [18:0] x);
        return x[7:0] ^ {5'h0, x[18:16]} ^ 8'h3c;
    endfunction : mem
    function automatic logic [18:0] nxt(input logic [18:0] x);
        return (x == 19'h7ffff) ? 19'h0 : 19'(x + 19'h1);
    endfunction : nxt
    // array content seen by the read path
    assign mem_data = mem(mem_addr);
    flash_cmd_read_path u_dut (.mclk(mclk), .rst_b(rst_b), .cs_pin_b(cs_b), .sck_pin(sck),
        .bidir_in_line_in(si_line), .bidir_in_line_out(bidir_out),
        .bidir_in_line_oe_b(bidir_oe_b), .so_out(so_out), .so_oe_b(so_oe_b),
        .mem_addr(mem_addr), .mem_data(mem_data), .cmd_code(cmd_code), .cmd_addr(cmd_addr),
        .cmd_strobe(cmd_strobe), .wdata(wdata), .wdata_strobe(wdata_strobe));
    spi_host u_host (.so_out(so_out), .so_oe_b(so_oe_b), .bidir_out(bidir_out),
        .bidir_oe_b(bidir_oe_b), .cs_b(cs_b), .sck(sck), .si_line(si_line),
        .rd_byte(rd_byte), .rd_tick(rd_tick));
    task automatic cmp_val(input logic [27:0] got, input logic [27:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_val
    // per-kind compares over the common counter
    task automatic cmp_cmd(input logic [27:0] got, input logic [27:0] exp);
        cmp_val(got, exp);
    endtask : cmp_cmd
    task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
        cmp_val({20'h0, got}, {20'h0, exp});
    endtask : cmp_byte
    task end_of_test();
        if (n_errors == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_of_test
    // results take the oldest note; a strobe with none noted fails
    // strobes looked at mid-cycle, where they have settled
    always @(negedge mclk) begin
        if (cmd_strobe === 1'b1) begin
            logic [27:0] e;
            e = exp_cmd.size() ? exp_cmd.pop_front() : 28'h0ffffff;
            cmp_cmd({e[27], cmd_code, e[27] ? cmd_addr : 19'h0}, e);
        end
        if (wdata_strobe === 1'b1) begin
            cmp_byte(wdata, exp_byte.size() ? exp_byte.pop_front() : ~wdata);
        end
    end
    always @(rd_tick) begin
        if ($time > 0) begin
            cmp_byte(rd_byte, exp_byte.size() ? exp_byte.pop_front() : ~rd_byte);
        end
    end
    // header of one frame, expectation noted first
    task automatic hdr(input logic [7:0] op, input int na, input int nd, input logic [23:0] a,
            input logic [27:0] e);
        exp_cmd.push_back(e);
        u_host.start();
        u_host.bits(op, 8);
        for (int i = 0; i < na; i++) u_host.bits(a[23 - 8 * i -: 8], 8);
        for (int i = 0; i < nd; i++) u_host.bits(8'($random(seed)), 8);
    endtask : hdr
    // array read of n bytes, then cut bits of a partial byte
    task automatic rd_run(input logic [7:0] op, input logic [23:0] a, input int n, input int cut);
        logic [18:0] p;
        int nd;
        p = a[18:0];
        nd = (op == flash_cmd_pkg::OP_READ_SLOW) ? 0 : 1;
        hdr(op, 3, nd, a, {1'b1, op, p});
        for (int i = 0; i < n; i++) begin
            exp_byte.push_back(mem(p));
            u_host.rd(op == flash_cmd_pkg::OP_READ_DUAL);
            p = nxt(p);
        end
        u_host.bits(8'h00, cut);
        u_host.stop();
        cmp_val({so_oe_b, bidir_oe_b}, 2'b11);
    endtask : rd_run
    initial begin
        logic [23:0] a;
        logic [18:0] cur;
        logic [7:0] op;
        logic [7:0] b;
        logic seq;
        int na;
        logic [27:0] ec;
        cur = 19'h0;
        repeat (12) @(posedge mclk);
        #1 rst_b = 1'b1;
        repeat (4) @(posedge mclk);
        #1;
        cmp_val({so_oe_b, bidir_oe_b, cmd_strobe}, 3'b110);
        rd_run(flash_cmd_pkg::OP_READ_SLOW, 24'hf7fffe, 4, 0);
        rd_run(flash_cmd_pkg::OP_READ_FAST, 24'($random(seed)), 3, 3);
        rd_run(flash_cmd_pkg::OP_READ_DUAL, 24'h07fffe, 3, 2);
        // unsupported opcode, then one frame cut inside its address and one inside its opcode
        u_host.start();
        u_host.bits(8'hff, 8);
        u_host.bits(flash_cmd_pkg::OP_READ_SLOW, 8);
        u_host.bits(8'h00, 8);
        cmp_val(so_oe_b, 1'b1);
        u_host.stop();
        u_host.start();
        u_host.bits(flash_cmd_pkg::OP_PROG, 8);
        u_host.bits(8'h01, 8);
        u_host.bits(8'h02, 5);
        u_host.stop();
        u_host.start();
        u_host.bits(flash_cmd_pkg::OP_READ_FAST, 5);
        u_host.stop();
        // every supported opcode except the three reads, with its byte counts
        foreach (tbl[k]) begin
            op = tbl[k][15:8];
            na = tbl[k][7:6];
            a = 24'($random(seed));
            seq = (na == 0) && (op == flash_cmd_pkg::OP_SEQ_PROG_A
                || op == flash_cmd_pkg::OP_SEQ_PROG_B);
            if (na != 0) cur = a[18:0];
            else if (seq) cur = nxt(cur);
            ec = {na != 0 || seq, op, (na != 0 || seq) ? cur : 19'h0};
            hdr(op, na, tbl[k][5:4], a, ec);
            if (tbl[k][3:2] != 0) begin
                b = (op == flash_cmd_pkg::OP_RESET) ? 8'hd0 : 8'($random(seed));
                exp_byte.push_back(b);
                u_host.bits(b, 8);
            end
            u_host.stop();
        end
        rd_run(flash_cmd_pkg::OP_READ_DUAL, 24'($random(seed)), 2, 1);
        repeat (50) @(posedge mclk);
        cmp_val(exp_cmd.size() + exp_byte.size(), 28'h0);
        end_of_test();
    end
    // hang guard
    initial begin
        #350000;
        n_errors++;
        end_of_test();
    end
endmodule : testbench
`default_nettype wire
